// file: shared/seam_seq_cfg.svh
`ifndef SEAM_SEQ_CFG_SVH
`define SEAM_SEQ_CFG_SVH
// extended setting value that unlocks wait-here seam operation
`define SEAM_CFG_ENABLE   8'h05
// cycle mode codes
`define MODE_REPEAT       8'h01
`define MODE_CHAINED      8'h02
`define MODE_WAIT_HERE    8'h05
// impulse count that marks a seam schedule (99 decimal)
`define SEAM_IMPULSES     8'h63
// schedules reached from the seventh and eleventh stage inputs (20 and 40)
`define SCHED_SEVENTH     7'h14
`define SCHED_ELEVENTH    7'h28
// reset values
`define SCHED_RESET       7'h00
`define COUNT_RESET       8'h00
`endif

// file: shared/seam_seq_pkg.sv
package seam_seq_pkg;

  // one schedule as held by the schedule store
  typedef struct packed {
    logic [7:0] squeeze;
    logic [7:0] weld;
    logic [7:0] percent;
    logic [7:0] hold;
    logic [7:0] off;
    logic [7:0] impulses;
    logic [7:0] cool;
    logic [7:0] valve;
    logic [7:0] cycle_mode;
    logic [7:0] slope_mode;
    logic [7:0] slope_count;
  } sched_t;

  // operator inputs and line zero crossing, all from pins
  typedef struct packed {
    logic line_zero_cross;
    logic third_stage_initiation;
    logic seventh_stage_initiation;
    logic eleventh_stage_initiation;
    logic sequence_stop_input;
    logic auxiliary_flow_input;
  } pins_t;

  typedef enum logic [5:0] {
    idle_s    = 6'h01,
    squeeze_s = 6'h02,
    weld_s    = 6'h04,
    cool_s    = 6'h08,
    hold_s    = 6'h10,
    off_s     = 6'h20
  } state_t;

endpackage : seam_seq_pkg

// file: logic/seam_weld_wait_here_sequencer.sv
`timescale 1ns/10ps
`include "seam_seq_cfg.svh"
// Notes on behaviour
// - seam behaviour only when extended setting equals 05
// - seam starts from third stage input; weld current follows squeeze
// - stop or auxiliary flow input ends seam welding, goes to hold
// - seventh stage jumps to schedule 20, eleventh to schedule 40
// - mode 00..04 or other impulse count leaves wait-here behaviour
// - nonzero cool alternates weld and cool intervals in seam
// - percent current taken from each chained schedule on its own
// - slope and weld function taken from each chained schedule
module seam_weld_wait_here_sequencer
  import seam_seq_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire pins_t      pins_i,
  input  wire logic [7:0] seam_cfg_i,
  input  wire logic [6:0] dial_sched_i,
  input  wire sched_t     sched_i,
  output logic [6:0]      sched_sel_o,
  output logic            weld_on_o,
  output logic [7:0]      percent_o,
  output logic [7:0]      slope_mode_o,
  output logic [7:0]      slope_count_o,
  output logic [7:0]      valve_o,
  output logic            busy_o,
  output logic            seam_active_o
);

  //--------------------------------------------------------------
  // input synchronisers and filter
  //--------------------------------------------------------------
  pins_t sync1_ff, sync2_ff, sync3_ff, flt_ff, prev_ff;
  pins_t nxt_flt, rise_w;

  // a change counts once stages two and three agree
  assign nxt_flt = (sync2_ff & sync3_ff) | (flt_ff & (sync2_ff | sync3_ff));
  assign rise_w  = flt_ff & ~prev_ff;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
      flt_ff   <= '0;
      prev_ff  <= '0;
    end
    else
    begin
      sync1_ff <= pins_i;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      flt_ff   <= nxt_flt;
      prev_ff  <= flt_ff;
    end
  end

  //--------------------------------------------------------------
  // decode
  //--------------------------------------------------------------
  function automatic logic cnt_hit(input logic [7:0] cnt, input logic [7:0] target);
    cnt_hit = (cnt >= target);
  endfunction : cnt_hit

  state_t     state_ff, nxt_state;
  logic [7:0] cnt_ff, nxt_cnt;
  logic [7:0] imp_ff, nxt_imp;
  logic [6:0] sel_ff, nxt_sel;
  logic [7:0] target_w;
  logic       tick_w, seam_w, halt_w, done_w, imp_last_w, cool_set_w;
  logic       jump7_w, jump11_w, chained_w, repeat_w;

  assign tick_w     = rise_w.line_zero_cross;
  // wait-here seam is live only while all three settings hold
  assign seam_w     = (seam_cfg_i == `SEAM_CFG_ENABLE)
                    && (sched_i.cycle_mode == `MODE_WAIT_HERE)
                    && (sched_i.impulses == `SEAM_IMPULSES);
  assign halt_w     = flt_ff.sequence_stop_input
                    | (seam_w & flt_ff.auxiliary_flow_input);
  assign jump7_w    = rise_w.seventh_stage_initiation;
  assign jump11_w   = rise_w.eleventh_stage_initiation;
  assign cool_set_w = (sched_i.cool != `COUNT_RESET);
  assign imp_last_w = ((imp_ff + 8'h01) >= sched_i.impulses);
  assign chained_w  = (sched_i.cycle_mode == `MODE_CHAINED);
  assign repeat_w   = (sched_i.cycle_mode == `MODE_REPEAT);

  // interval length for the current state
  assign target_w = (state_ff == squeeze_s) ? sched_i.squeeze :
                    (state_ff == weld_s)    ? sched_i.weld    :
                    (state_ff == cool_s)    ? sched_i.cool    :
                    (state_ff == hold_s)    ? sched_i.hold    :
                    (state_ff == off_s)     ? sched_i.off     : `COUNT_RESET;
  assign done_w   = cnt_hit(cnt_ff, target_w);

  //--------------------------------------------------------------
  // sequence state machine
  //--------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    nxt_sel   = sel_ff;
    nxt_imp   = imp_ff;
    nxt_cnt   = tick_w ? 8'(cnt_ff + 8'h01) : cnt_ff;
    unique case (state_ff)
      idle_s:
      begin
        nxt_cnt = `COUNT_RESET;
        if (rise_w.third_stage_initiation)
        begin
          nxt_sel   = dial_sched_i;
          nxt_state = squeeze_s;
        end
        else if (jump7_w || jump11_w)
        begin
          nxt_sel   = jump7_w ? `SCHED_SEVENTH : `SCHED_ELEVENTH;
          nxt_state = squeeze_s;
        end
      end
      squeeze_s:
      begin
        nxt_imp = `COUNT_RESET;
        if (flt_ff.sequence_stop_input)
          nxt_state = idle_s;
        else if (done_w)
        begin
          nxt_state = weld_s;
          nxt_cnt   = `COUNT_RESET;
        end
      end
      weld_s, cool_s:
      begin
        if (seam_w && halt_w)
        begin
          nxt_state = hold_s;
          nxt_cnt   = `COUNT_RESET;
        end
        else if (seam_w && (jump7_w || jump11_w))
        begin
          nxt_sel   = jump7_w ? `SCHED_SEVENTH : `SCHED_ELEVENTH;
          nxt_state = squeeze_s;
          nxt_cnt   = `COUNT_RESET;
        end
        else if (!seam_w && flt_ff.sequence_stop_input)
          nxt_state = idle_s;
        else if (done_w && state_ff == cool_s)
        begin
          nxt_state = weld_s;
          nxt_cnt   = `COUNT_RESET;
        end
        else if (done_w)
        begin
          nxt_cnt = `COUNT_RESET;
          nxt_imp = 8'(imp_ff + 8'h01);
          if (seam_w)
            nxt_state = cool_set_w ? cool_s : weld_s;
          else if (imp_last_w)
            nxt_state = hold_s;
          else if (cool_set_w)
            nxt_state = cool_s;
        end
      end
      hold_s:
      begin
        if (done_w)
        begin
          nxt_state = off_s;
          nxt_cnt   = `COUNT_RESET;
        end
      end
      off_s:
      begin
        if (done_w)
        begin
          nxt_cnt = `COUNT_RESET;
          if (chained_w)
          begin
            nxt_sel   = 7'(sel_ff + 7'h01);
            nxt_state = squeeze_s;
          end
          else if (repeat_w && flt_ff.third_stage_initiation)
            nxt_state = squeeze_s;
          else
            nxt_state = idle_s;
        end
      end
    endcase
  end

  // state and counters
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_ff <= idle_s;
      cnt_ff   <= `COUNT_RESET;
      imp_ff   <= `COUNT_RESET;
      sel_ff   <= `SCHED_RESET;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      imp_ff   <= nxt_imp;
      sel_ff   <= nxt_sel;
    end
  end

  //--------------------------------------------------------------
  // registered outputs
  //--------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      weld_on_o     <= 1'b0;
      percent_o     <= `COUNT_RESET;
      slope_mode_o  <= `COUNT_RESET;
      slope_count_o <= `COUNT_RESET;
      valve_o       <= `COUNT_RESET;
      busy_o        <= 1'b0;
      seam_active_o <= 1'b0;
    end
    else
    begin
      weld_on_o     <= (nxt_state == weld_s);
      percent_o     <= sched_i.percent;
      slope_mode_o  <= sched_i.slope_mode;
      slope_count_o <= sched_i.slope_count;
      valve_o       <= (nxt_state == idle_s) ? `COUNT_RESET : sched_i.valve;
      busy_o        <= (nxt_state != idle_s);
      seam_active_o <= seam_w && (nxt_state != idle_s);
    end
  end

  assign sched_sel_o = sel_ff;

  //--------------------------------------------------------------
  // assertions
  //--------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  start_third_a: assert property (
    (state_ff == idle_s && rise_w.third_stage_initiation)
    |=> (state_ff == squeeze_s && sel_ff == $past(dial_sched_i)))
    else $error("third stage start did not enter squeeze");
  squeeze_weld_a: assert property (
    (state_ff == squeeze_s && done_w && !flt_ff.sequence_stop_input)
    |=> (state_ff == weld_s) ##0 weld_on_o)
    else $error("weld did not follow squeeze");
  seam_halt_a: assert property (
    ((state_ff == weld_s || state_ff == cool_s) && seam_w && halt_w)
    |=> (state_ff == hold_s && !weld_on_o))
    else $error("stop did not end seam welding");
  seam_jump_a: assert property (
    ((state_ff == weld_s || state_ff == cool_s) && seam_w && !halt_w && jump7_w)
    |=> (state_ff == squeeze_s && sel_ff == `SCHED_SEVENTH))
    else $error("seventh stage did not jump to schedule 20");
  seam_jump40_a: assert property (
    ((state_ff == weld_s || state_ff == cool_s) && seam_w && !halt_w
     && !jump7_w && jump11_w)
    |=> (sel_ff == `SCHED_ELEVENTH))
    else $error("eleventh stage did not jump to schedule 40");
  seam_steady_a: assert property (
    (state_ff == weld_s && seam_w && !cool_set_w && !halt_w && !jump7_w && !jump11_w)
    |=> (state_ff == weld_s))
    else $error("continuous seam weld dropped");
  seam_cool_a: assert property (
    (state_ff == weld_s && seam_w && cool_set_w && done_w
     && !halt_w && !jump7_w && !jump11_w)
    |=> (state_ff == cool_s) ##1 !weld_on_o)
    else $error("intermittent seam skipped cool");
  plain_end_a: assert property (
    (state_ff == weld_s && !seam_w && done_w && imp_last_w
     && !flt_ff.sequence_stop_input)
    |=> (state_ff == hold_s))
    else $error("non seam schedule did not end weld");
  line_count_a: assert property (
    (state_ff == hold_s && !tick_w && !done_w) |=> $stable(cnt_ff))
    else $error("interval advanced without line tick");
  percent_track_a: assert property (
    busy_o |-> ##1 (percent_o == $past(sched_i.percent)
                    && slope_mode_o == $past(sched_i.slope_mode)))
    else $error("schedule current not applied");
  cover_seam_long_c: cover property (
    (state_ff == weld_s && seam_w && !cool_set_w) [*8]);
  cover_seam_cool_c: cover property (
    (state_ff == weld_s && seam_w) ##1 (state_ff == cool_s));
  cover_jump_c: cover property (
    (state_ff == weld_s && seam_w && jump7_w) ##1 (sel_ff == `SCHED_SEVENTH));
  cover_chain_c: cover property (
    (state_ff == off_s && done_w && chained_w) ##1 (state_ff == squeeze_s));

endmodule : seam_weld_wait_here_sequencer

// file: testbench/operator_panel_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// operator switches and line zero crossing
// ----------------------------------------
module operator_panel_model
  import seam_seq_pkg::*;
(
  input  wire logic clk_i,
  output pins_t     pins_o
);
  logic [2:0] phase_ff = 3'h0;
  logic [4:0] sw_ff    = 5'h00;

  // line tick every 8 clocks, high for 4 so the pin filter keeps it
  always @(posedge clk_i)
  begin
    phase_ff <= #1 phase_ff + 3'h1;
  end

  // open switches read low, closed read high
  assign pins_o = {phase_ff[2], sw_ff};

  // close or open one switch just after an edge
  task automatic set_sw(input int idx, input logic v);
    @(posedge clk_i);
    #1 sw_ff[idx] = v;
  endtask : set_sw

  // open every switch
  task automatic clear_all();
    @(posedge clk_i);
    #1 sw_ff = 5'h00;
  endtask : clear_all
endmodule : operator_panel_model

// file: testbench/test_seam_weld_wait_here_sequencer.sv
`timescale 1ns/10ps
`include "seam_seq_cfg.svh"
module test_seam_weld_wait_here_sequencer import seam_seq_pkg::*;;
  // ----------------------------------------
  // bench signals, clock and schedule store
  // ----------------------------------------
  localparam int THIRD = 4;
  localparam int SEVENTH = 3;
  localparam int ELEVENTH = 2;
  localparam int STOP = 1;
  logic       clk_i        = 1'b0;
  logic       resetn_i     = 1'b0;
  logic [7:0] seam_cfg_i   = `SEAM_CFG_ENABLE;
  logic [6:0] dial_sched_i = 7'h00;
  pins_t      pins_i;
  sched_t     sched_i;
  sched_t     store [0:127];
  logic [6:0] sched_sel_o;
  logic       weld_on_o;
  logic       busy_o;
  logic       seam_active_o;
  logic [7:0] percent_o;
  logic [7:0] slope_mode_o;
  logic [7:0] slope_count_o;
  logic [7:0] valve_o;
  int         mismatches  = 0;
  int         check_count = 0;
  int         cycles      = 0;
  int         n;

  always #5 clk_i = ~clk_i;

  // store answers for the selected schedule
  assign sched_i = store[sched_sel_o];

  operator_panel_model panel (.clk_i(clk_i), .pins_o(pins_i));

  seam_weld_wait_here_sequencer DUT (
    .clk_i(clk_i), .resetn_i(resetn_i), .pins_i(pins_i), .seam_cfg_i(seam_cfg_i),
    .dial_sched_i(dial_sched_i), .sched_i(sched_i), .sched_sel_o(sched_sel_o),
    .weld_on_o(weld_on_o), .percent_o(percent_o), .slope_mode_o(slope_mode_o),
    .slope_count_o(slope_count_o), .valve_o(valve_o), .busy_o(busy_o),
    .seam_active_o(seam_active_o)
  );

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  task automatic check1(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : check1

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check8

  // wait for weld_on (0), busy (1) or selection (2) to reach val
  task automatic wait_for(input int sel, input logic [6:0] val, input int lim, output int k);
    for (k = 0; k < lim; k++)
    begin
      @(posedge clk_i);
      #1;
      if ((sel == 0 ? {6'h00, weld_on_o} : sel == 1 ? {6'h00, busy_o} : sched_sel_o) === val)
        return;
    end
    check1("wait", 1'b1, 1'b0);
  endtask : wait_for

  task automatic start(input logic [6:0] s);
    @(posedge clk_i);
    #1 dial_sched_i = s;
    panel.set_sw(THIRD, 1'b1);
    wait_for(1, 7'h01, 20, n);
    check8("sched_sel", {1'b0, s}, {1'b0, sched_sel_o});
  endtask : start

  task automatic stop_all(input int lim);
    panel.set_sw(STOP, 1'b1);
    wait_for(1, 7'h00, lim, n);
    panel.clear_all();
    repeat (6) @(posedge clk_i);
  endtask : stop_all

  function automatic sched_t mk(input logic [7:0] mode, imp, cl, pct, slp);
    mk = '{squeeze:8'h02, weld:8'h02, percent:pct, hold:8'h01, off:8'h01, impulses:imp,
           cool:cl, valve:8'h01, cycle_mode:mode, slope_mode:slp, slope_count:slp};
  endfunction : mk

  // hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  // main sequence
  initial
  begin
    for (int i = 0; i < 128; i++)
      store[i] = mk(8'h00, 8'h01, 8'h00, 8'h10, 8'h00);
    store[13] = mk(`MODE_WAIT_HERE, `SEAM_IMPULSES, 8'h00, 8'h28, 8'h00);
    store[14] = mk(`MODE_WAIT_HERE, `SEAM_IMPULSES, 8'h02, 8'h32, 8'h00);
    store[20] = mk(8'h00, 8'h01, 8'h00, 8'h1E, 8'h02);
    store[40] = mk(8'h00, 8'h01, 8'h00, 8'h3C, 8'h03);
    for (int i = 0; i < 5; i++)
      store[30 + i] = mk(8'(i), `SEAM_IMPULSES, 8'h00, 8'h10, 8'h00);
    store[35] = mk(`MODE_WAIT_HERE, 8'h62, 8'h00, 8'h10, 8'h00);
    repeat (8) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    repeat (8) @(posedge clk_i);
    // continuous seam halted by stop, then by auxiliary flow
    for (int h = 1; h >= 0; h--)
    begin
      start(7'h0D);
      wait_for(0, 7'h01, 200, n);
      check1("seam_active", 1'b1, seam_active_o);
      check8("percent", 8'h28, percent_o);
      check8("valve", 8'h01, valve_o);
      repeat (300) @(posedge clk_i);
      check1("weld_on", 1'b1, weld_on_o);
      panel.set_sw(h, 1'b1);
      wait_for(0, 7'h00, 8, n);
      check1("busy", 1'b1, busy_o);
      stop_all(200);
      check8("valve idle", 8'h00, valve_o);
    end
    // jumps to the later schedules
    for (int j = 0; j < 2; j++)
    begin
      start(7'h0D);
      wait_for(0, 7'h01, 200, n);
      panel.set_sw(j == 0 ? SEVENTH : ELEVENTH, 1'b1);
      wait_for(2, j == 0 ? `SCHED_SEVENTH : `SCHED_ELEVENTH, 8, n);
      repeat (2) @(posedge clk_i);
      check8("percent", j == 0 ? 8'h1E : 8'h3C, percent_o);
      check8("slope_mode", j == 0 ? 8'h02 : 8'h03, slope_mode_o);
      check8("slope_count", j == 0 ? 8'h02 : 8'h03, slope_count_o);
      stop_all(200);
    end
    // modes 00..04, wrong impulses, setting off: no seam, stop aborts
    for (int i = 0; i < 7; i++)
    begin
      #1 seam_cfg_i = i < 6 ? `SEAM_CFG_ENABLE : 8'h00;
      start(i < 6 ? 7'(30 + i) : 7'h0D);
      repeat (3) @(posedge clk_i);
      check1("seam_active", 1'b0, seam_active_o);
      stop_all(12);
    end
    #1 seam_cfg_i = `SEAM_CFG_ENABLE;
    // intermittent seam
    start(7'h0E);
    wait_for(0, 7'h01, 200, n);
    wait_for(0, 7'h00, 40, n);
    wait_for(0, 7'h01, 40, n);
    check1("cool span", 1'b1, n >= 8 && n <= 24);
    check1("seam_active", 1'b1, seam_active_o);
    stop_all(200);
    wrap_up();
  end
endmodule : test_seam_weld_wait_here_sequencer
